/* include/pcu_pkg.sv */
// Overview of operation
// RULE1: Enable register bits 31 to 8 read zero and ignore writes.
// RULE2: Bits 7..4 enable overvoltage irqs: core, five volt, main, monitor.
// RULE3: Bits 3..0 enable undervoltage irqs: core, five volt, main, monitor.
// RULE4: Power-up: reference, then bias, then modules singly, then measurement.
// RULE5: Stop exit restores register contents saved before Stop entry.
// RULE6: Sleep and Stop entry shut modules down in controlled order.
// RULE7: Driver supply overvolt shutdown enabled by 0, enters Sleep.
// RULE8: Driver overvolt turns off driver, pump, attenuators; back on after.
// RULE9: Junction overtemperature puts system into Sleep.
// RULE10: Overtemp stage control 0: pump and driver off after 64us.
// RULE11: Overtemperature lasting 1ms enters Sleep.
// RULE12: Immediate stage control 0: pump and driver off at once.
// RULE13: Clock loss can shut power modules down.
// RULE14: Internal supply fail can shut whole system down.
// RULE15: Main supply undervoltage can shut transceiver down.
// RULE16: Software should reduce dissipation on temperature prewarning.
// RULE17: Driver overvolt sleep disable is status bit 14, 0 enables.
// RULE18: Overtemp stage disable is status bit 24, 0 enables.
// RULE19: Immediate stage disable is status bit 7, 0 enables.
// RULE20: Clock loss disable is status bit 25, 0 enables.
// RULE21: Supply irq raised only on matching event with enable set.
// RULE22: Power-down runs reverse of power-up, reference last.
`default_nettype none
package pcu_pkg;
  // ****************************************
  // Register map
  // ****************************************
  localparam logic [7:0]  IRQ_EN_OFFSET     = 8'h2c;
  localparam logic [7:0]  CTRL_STS_OFFSET   = 8'h30;
  localparam logic [7:0]  MODE_OFFSET       = 8'h34;
  localparam logic [31:0] IRQ_EN_RESET      = 32'h0000_00ff;
  localparam logic [31:0] CTRL_STS_RESET    = 32'h82e3_7ef3;
  localparam logic [31:0] CTRL_STS_RW_MASK  = 32'h0700_4182;
  localparam int          DRV_OV_SLEEP_BIT  = 14;
  localparam int          OT_STAGE_BIT      = 24;
  localparam int          FAIL_STAGE_BIT    = 7;
  localparam int          CLK_LOSS_BIT      = 25;
  localparam int          LIN_UV_BIT        = 8;
  localparam int          MODE_SLEEP_BIT    = 0;
  localparam int          MODE_STOP_BIT     = 1;
  localparam int          MODE_WAKE_BIT     = 2;
  localparam int          NUM_MODULES       = 7;
  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_MHZ        = 10;
  localparam int OT_STAGE_US    = 64;
  localparam int OT_SLEEP_MS    = 1;
  localparam int STEP_CYCLES    = 4;
  localparam int OT_STAGE_CYC   = OT_STAGE_US * CLK_MHZ;
  localparam int OT_SLEEP_CYC   = OT_SLEEP_MS * 1000 * CLK_MHZ;
  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [2:0] {
    ST_OFF, ST_REF, ST_BIAS, ST_MODS, ST_RUN, ST_DOWN
  } seq_e;
  typedef struct packed {
    logic [3:0] ov;
    logic [3:0] uv;
  } supply_evt_s;
  typedef struct packed {
    logic charge_pump;
    logic bridge_driver;
    logic attenuators;
    logic transceiver;
  } stage_off_s;
endpackage : pcu_pkg
`default_nettype wire

/* rtl/input_sync.sv */
`timescale 1ns/10ps
`default_nettype none
module input_sync #(
  parameter int W = 1
) (
  input  wire logic         clk_sys_in,
  input  wire logic         rst_n_in,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] level_out
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] lvl;
  } state_s;
  state_s r;
  state_s next_r;
  // Three stages, change accepted when stages two and three agree
  always_comb begin
    next_r    = r;
    next_r.s1 = async_in;
    next_r.s2 = r.s1;
    next_r.s3 = r.s2;
    for (int i = 0; i < W; i++) begin
      if (r.s2[i] == r.s3[i]) begin
        next_r.lvl[i] = r.s3[i];
      end
    end
  end
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end
  assign level_out = r.lvl;
endmodule : input_sync
`default_nettype wire

/* rtl/persist_timer.sv */
`timescale 1ns/10ps
`default_nettype none
module persist_timer #(
  parameter int LIMIT = 16
) (
  input  wire logic clk_sys_in,
  input  wire logic rst_n_in,
  input  wire logic cond_in,
  output logic      expired_out
);
  typedef struct packed {
    logic [31:0] cnt;
    logic        hit;
  } state_s;
  state_s r;
  state_s next_r;
  // Counts while condition holds, restarts when it drops
  always_comb begin
    next_r = r;
    if (!cond_in) begin
      next_r.cnt = '0;
      next_r.hit = 1'b0;
    end else if (r.cnt < 32'(LIMIT - 1)) begin
      next_r.cnt = r.cnt + 32'h1;
    end else begin
      next_r.hit = 1'b1;
    end
  end
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end
  assign expired_out = r.hit;
endmodule : persist_timer
`default_nettype wire

/* rtl/power_module_sequencer.sv */
`timescale 1ns/10ps
`default_nettype none
module power_module_sequencer #(
  parameter int OT_SLEEP_CYC = pcu_pkg::OT_SLEEP_CYC
) (
  input  wire logic                            clk_sys_in,
  input  wire logic                            rst_n_in,
  // Register port
  input  wire logic [7:0]                      reg_addr_in,
  input  wire logic [31:0]                     reg_wdata_in,
  input  wire logic                            reg_wr_in,
  input  wire logic                            reg_rd_in,
  output logic      [31:0]                     reg_rdata_out,
  // Measurement threshold events (asynchronous)
  input  wire pcu_pkg::supply_evt_s            supply_evt_in,
  input  wire logic                            driver_supply_ov_in,
  input  wire logic                            overtemp_in,
  input  wire logic                            clock_loss_in,
  input  wire logic                            supply_fail_in,
  input  wire logic                            main_supply_uv_in,
  // Supply interrupt requests
  output pcu_pkg::supply_evt_s                 supply_irq_out,
  // Module enables, index 0 reference, 1 bias, then analog modules
  output logic [pcu_pkg::NUM_MODULES-1:0]      module_en_out,
  output logic                                 measure_start_out,
  output pcu_pkg::stage_off_s                  stage_off_out,
  output logic                                 sleep_req_out,
  output logic                                 in_stop_out,
  output logic                                 seq_busy_out
);
  localparam int NM = pcu_pkg::NUM_MODULES;

  // ****************************************
  // Input synchronisation
  // ****************************************
  logic [12:0] sync_lvl;
  input_sync #(.W(13)) u_sync (
    .clk_sys_in (clk_sys_in),
    .rst_n_in   (rst_n_in),
    .async_in   ({supply_evt_in, driver_supply_ov_in, overtemp_in,
                  clock_loss_in, supply_fail_in, main_supply_uv_in}),
    .level_out  (sync_lvl)
  );
  pcu_pkg::supply_evt_s evt;
  logic drv_ov;
  logic ot;
  logic clk_loss;
  logic sup_fail;
  logic main_uv;
  assign evt      = sync_lvl[12:5];
  assign drv_ov   = sync_lvl[4];
  assign ot       = sync_lvl[3];
  assign clk_loss = sync_lvl[2];
  assign sup_fail = sync_lvl[1];
  assign main_uv  = sync_lvl[0];

  // ****************************************
  // Overtemperature timers
  // ****************************************
  logic ot_stage_exp;
  logic ot_sleep_exp;
  persist_timer #(.LIMIT(pcu_pkg::OT_STAGE_CYC)) u_ot_stage (
    .clk_sys_in  (clk_sys_in),
    .rst_n_in    (rst_n_in),
    .cond_in     (ot),
    .expired_out (ot_stage_exp)
  );
  persist_timer #(.LIMIT(OT_SLEEP_CYC)) u_ot_sleep (
    .clk_sys_in  (clk_sys_in),
    .rst_n_in    (rst_n_in),
    .cond_in     (ot),
    .expired_out (ot_sleep_exp)
  );

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic [7:0]           irq_en;
    logic [31:0]          ctrl;
    logic [31:0]          saved_ctrl;
    logic [7:0]           saved_irq_en;
    logic                 saved_valid;
    pcu_pkg::seq_e        st;
    logic [3:0]           idx;
    logic [7:0]           step;
    logic [NM-1:0]        en;
    logic                 meas;
    logic                 down_stop;
    logic                 stop;
    logic                 sleep;
    pcu_pkg::supply_evt_s evt_q;
    pcu_pkg::supply_evt_s irq;
    logic [31:0]          rdata;
  } state_s;
  state_s r;
  state_s next_r;

  // Read decode helper
  function automatic logic [31:0] read_mux(input logic [7:0] a, input state_s s);
    if (a == pcu_pkg::IRQ_EN_OFFSET) begin
      read_mux = {24'h000000, s.irq_en};           // see RULE1
    end else if (a == pcu_pkg::CTRL_STS_OFFSET) begin
      read_mux = s.ctrl;
    end else if (a == pcu_pkg::MODE_OFFSET) begin
      read_mux = {24'h000000, 1'b0, 3'(s.st), 1'b0, s.stop, s.sleep, s.meas};
    end else begin
      read_mux = 32'h0000_0000;
    end
  endfunction : read_mux

  logic go_sleep;
  logic drv_ov_act;
  logic [3:0] step_cnt;

  assign drv_ov_act = drv_ov && !r.ctrl[pcu_pkg::DRV_OV_SLEEP_BIT];   // see RULE7 see RULE17
  assign step_cnt   = 4'(pcu_pkg::STEP_CYCLES - 1);
  // Protective requests to enter Sleep
  assign go_sleep   = drv_ov_act || ot_sleep_exp || sup_fail;          // see RULE9 see RULE11 see RULE14

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    next_r       = r;
    next_r.rdata = 32'h0000_0000;
    next_r.evt_q = evt;
    // Register writes
    if (reg_wr_in) begin
      if (reg_addr_in == pcu_pkg::IRQ_EN_OFFSET) begin
        next_r.irq_en = reg_wdata_in[7:0];           // see RULE1
      end else if (reg_addr_in == pcu_pkg::CTRL_STS_OFFSET) begin
        next_r.ctrl = (r.ctrl & ~pcu_pkg::CTRL_STS_RW_MASK)
                    | (reg_wdata_in & pcu_pkg::CTRL_STS_RW_MASK);
      end else if (reg_addr_in == pcu_pkg::MODE_OFFSET) begin
        if (reg_wdata_in[pcu_pkg::MODE_SLEEP_BIT] && r.st == pcu_pkg::ST_RUN) begin
          next_r.st        = pcu_pkg::ST_DOWN;
          next_r.down_stop = 1'b0;
          next_r.idx       = 4'(NM);
        end else if (reg_wdata_in[pcu_pkg::MODE_STOP_BIT] && r.st == pcu_pkg::ST_RUN) begin
          next_r.st           = pcu_pkg::ST_DOWN;
          next_r.down_stop    = 1'b1;
          next_r.idx          = 4'(NM);
          next_r.saved_ctrl   = r.ctrl;              // see RULE5
          next_r.saved_irq_en = r.irq_en;
          next_r.saved_valid  = 1'b1;
        end else if (reg_wdata_in[pcu_pkg::MODE_WAKE_BIT] && r.st == pcu_pkg::ST_OFF) begin
          next_r.st    = pcu_pkg::ST_REF;
          next_r.sleep = 1'b0;
          next_r.stop  = 1'b0;                       // Leaves low power at once
          next_r.step  = '0;
        end
      end
    end
    if (reg_rd_in) begin
      next_r.rdata = read_mux(reg_addr_in, r);
    end
    // Supply irq pulses on rising threshold events
    next_r.irq.ov = evt.ov & ~r.evt_q.ov & r.irq_en[7:4];   // see RULE2 see RULE21
    next_r.irq.uv = evt.uv & ~r.evt_q.uv & r.irq_en[3:0];   // see RULE3 see RULE21
    // Sequencer
    case (r.st)
      pcu_pkg::ST_OFF: begin
        next_r.meas = 1'b0;
      end
      pcu_pkg::ST_REF: begin
        next_r.en[0] = 1'b1;                         // see RULE4
        next_r.step  = r.step + 8'h01;
        if (r.step[3:0] == step_cnt) begin
          next_r.st   = pcu_pkg::ST_BIAS;
          next_r.step = '0;
        end
      end
      pcu_pkg::ST_BIAS: begin
        next_r.en[1] = 1'b1;                         // see RULE4
        next_r.step  = r.step + 8'h01;
        if (r.step[3:0] == step_cnt) begin
          next_r.st   = pcu_pkg::ST_MODS;
          next_r.step = '0;
          next_r.idx  = 4'h2;
        end
      end
      pcu_pkg::ST_MODS: begin
        next_r.en[r.idx[2:0]] = 1'b1;                // see RULE4
        next_r.step           = r.step + 8'h01;
        if (r.step[3:0] == step_cnt) begin
          next_r.step = '0;
          if (r.idx == 4'(NM - 1)) begin
            next_r.st   = pcu_pkg::ST_RUN;
            next_r.meas = 1'b1;                      // see RULE4
            if (r.saved_valid) begin
              next_r.ctrl        = r.saved_ctrl;     // see RULE5
              next_r.irq_en      = r.saved_irq_en;
              next_r.saved_valid = 1'b0;
              next_r.stop        = 1'b0;
            end
          end else begin
            next_r.idx = r.idx + 4'h1;
          end
        end
      end
      pcu_pkg::ST_RUN: begin
        if (go_sleep) begin
          next_r.st        = pcu_pkg::ST_DOWN;
          next_r.down_stop = 1'b0;
          next_r.idx       = 4'(NM);
        end
      end
      pcu_pkg::ST_DOWN: begin
        next_r.meas = 1'b0;                          // see RULE6
        next_r.step = r.step + 8'h01;
        if (r.step[3:0] == step_cnt) begin
          next_r.step = '0;
          if (r.idx == 4'h0) begin
            next_r.st    = pcu_pkg::ST_OFF;
            next_r.sleep = !r.down_stop;
            next_r.stop  = r.down_stop;
          end else begin
            next_r.en[r.idx[2:0] - 3'h1] = 1'b0;     // see RULE22
            next_r.idx = r.idx - 4'h1;
          end
        end
      end
      default: begin
        next_r.st = pcu_pkg::ST_OFF;
      end
    endcase
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      r        <= '0;
      r.irq_en <= pcu_pkg::IRQ_EN_RESET[7:0];
      r.ctrl   <= pcu_pkg::CTRL_STS_RESET;
      r.st     <= pcu_pkg::ST_REF;
    end else begin
      r <= next_r;
    end
  end

  // ****************************************
  // Protective stage shutdowns
  // ****************************************
  logic ot_stage_off;
  logic clk_stage_off;
  assign ot_stage_off  = (ot_stage_exp && !r.ctrl[pcu_pkg::OT_STAGE_BIT])    // see RULE10 see RULE18
                      || (ot && !r.ctrl[pcu_pkg::FAIL_STAGE_BIT]);          // see RULE12 see RULE19
  assign clk_stage_off = clk_loss && !r.ctrl[pcu_pkg::CLK_LOSS_BIT];       // see RULE13 see RULE20

  always_comb begin
    stage_off_out.charge_pump   = ot_stage_off || clk_stage_off || drv_ov_act;  // see RULE8
    stage_off_out.bridge_driver = ot_stage_off || clk_stage_off || drv_ov_act;  // see RULE8
    stage_off_out.attenuators   = drv_ov_act;                                   // see RULE8
    stage_off_out.transceiver   = main_uv && !r.ctrl[pcu_pkg::LIN_UV_BIT];      // see RULE15
  end

  assign reg_rdata_out     = r.rdata;
  assign supply_irq_out    = r.irq;
  assign module_en_out     = r.en;
  assign measure_start_out = r.meas;
  assign sleep_req_out     = r.sleep;
  assign in_stop_out       = r.stop;
  assign seq_busy_out      = (r.st != pcu_pkg::ST_RUN) && (r.st != pcu_pkg::ST_OFF);
endmodule : power_module_sequencer
`default_nettype wire

/* tb/afe_model.sv */
`timescale 1ns/10ps
`default_nettype none
module afe_model #(
  parameter int LAG = 23
) (
  input wire logic             clk_sys_in,
  input wire logic [12:0]      lvl_in,
  output pcu_pkg::supply_evt_s supply_evt_out,
  output logic [4:0]           fault_out
);
  // Comparator levels land off the clock edge
  initial {supply_evt_out, fault_out} = 13'h0;
  always @(posedge clk_sys_in) begin
    supply_evt_out <= #(LAG) lvl_in[12:5];
    fault_out <= #(LAG) lvl_in[4:0];
  end
endmodule : afe_model
`default_nettype wire

/* tb/pms_assertions.sv */
`timescale 1ns/10ps
`default_nettype none
module pms_checker #(
  parameter int OT_SLEEP_CYC = 50
) (
  input wire logic                            clk_sys_in,
  input wire logic                            rst_n_in,
  input wire logic [7:0]                      reg_addr_in,
  input wire logic                            reg_rd_in,
  input wire logic [31:0]                     reg_rdata_out,
  input wire pcu_pkg::supply_evt_s            supply_evt_in,
  input wire logic                            overtemp_in,
  input wire pcu_pkg::supply_evt_s            supply_irq_out,
  input wire logic [pcu_pkg::NUM_MODULES-1:0] module_en_out,
  input wire logic                            measure_start_out,
  input wire pcu_pkg::stage_off_s             stage_off_out,
  input wire logic                            sleep_req_out,
  input wire logic                            in_stop_out
);
  // ****
  // Helpers
  // ****
  logic [7:0] ev;
  logic [7:0] irq;
  int         ot_run;
  assign ev = supply_evt_in;
  assign irq = supply_irq_out;
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!rst_n_in);
  // Overtemperature held since the device was running
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in || !overtemp_in) ot_run <= 0;
    else if (ot_run != 0 || measure_start_out) ot_run <= ot_run + 1;
  end
  // ****
  // Properties
  // ****
  property p_rsv_zero;
    reg_rd_in && reg_addr_in == pcu_pkg::IRQ_EN_OFFSET |=> reg_rdata_out[31:8] == 24'h0;
  endproperty
  a_rsv_zero: assert property (p_rsv_zero) else $error("enable upper bits set");
  property p_irq_cause;
    (irq & ~($past(ev, 2) | $past(ev, 3) | $past(ev, 4) | $past(ev, 5))) == 8'h0;
  endproperty
  a_irq_cause: assert property (p_irq_cause) else $error("irq without event");
  property p_prefix;
    (module_en_out & ~{module_en_out[5:0], 1'b1}) == 7'h0;
  endproperty
  a_prefix: assert property (p_prefix) else $error("module order broken");
  property p_one_step;
    $onehot0(module_en_out ^ $past(module_en_out));
  endproperty
  a_one_step: assert property (p_one_step) else $error("modules switched together");
  property p_meas;
    measure_start_out |-> &module_en_out;
  endproperty
  a_meas: assert property (p_meas) else $error("measurement before modules");
  property p_low_off;
    sleep_req_out || in_stop_out |-> module_en_out == 7'h0 && !measure_start_out;
  endproperty
  a_low_off: assert property (p_low_off) else $error("modules on in low power");
  property p_pump_drv;
    stage_off_out.charge_pump == stage_off_out.bridge_driver;
  endproperty
  a_pump_drv: assert property (p_pump_drv) else $error("pump and driver differ");
  property p_att;
    stage_off_out.attenuators |-> stage_off_out.charge_pump;
  endproperty
  a_att: assert property (p_att) else $error("attenuators off alone");
  property p_ot_sleep;
    ot_run == OT_SLEEP_CYC + 60 |-> module_en_out == 7'h0;
  endproperty
  a_ot_sleep: assert property (p_ot_sleep) else $error("no sleep on overtemp");
  c_irq: cover property (irq != 8'h0);
  c_sleep: cover property (sleep_req_out);
  c_stop: cover property (in_stop_out);
endmodule : pms_checker
bind power_module_sequencer pms_checker #(.OT_SLEEP_CYC(OT_SLEEP_CYC)) u_chk (
  .clk_sys_in, .rst_n_in, .reg_addr_in, .reg_rd_in, .reg_rdata_out, .supply_evt_in,
  .overtemp_in, .supply_irq_out, .module_en_out, .measure_start_out, .stage_off_out,
  .sleep_req_out, .in_stop_out
);
`default_nettype wire

/* tb/power_module_sequencer_test.sv */
`timescale 1ns/10ps
`default_nettype none
module power_module_sequencer_test;
  logic                 clk_sys = 1'b0;
  logic                 rst_n = 1'b0;
  logic [7:0]           reg_addr = 8'h00;
  logic [31:0]          reg_wdata = 32'h0;
  logic                 reg_wr = 1'b0;
  logic                 reg_rd = 1'b0;
  logic [12:0]          lvl = 13'h0;
  logic [31:0]          rdata, d, m_irq, m_ctrl, saved;
  pcu_pkg::supply_evt_s evt, irq;
  pcu_pkg::stage_off_s  soff;
  logic [4:0]           flt;
  logic [6:0]           men;
  logic                 meas, slp, stp;
  logic                 busy;
  logic [7:0]           mon;
  int                   n_errors = 0;
  int                   total_checks = 0;
  // Watched levels: stage offs, run, stop, sleep, attenuators on
  assign mon = {~soff.attenuators, slp, stp, meas, soff};
  always #50 clk_sys = ~clk_sys;
  afe_model u_afe (.clk_sys_in(clk_sys), .lvl_in(lvl), .supply_evt_out(evt), .fault_out(flt));
  power_module_sequencer #(.OT_SLEEP_CYC(800)) u_dut (
    .clk_sys_in(clk_sys), .rst_n_in(rst_n), .reg_addr_in(reg_addr), .reg_wdata_in(reg_wdata),
    .reg_wr_in(reg_wr), .reg_rd_in(reg_rd), .reg_rdata_out(rdata), .supply_evt_in(evt),
    .driver_supply_ov_in(flt[4]), .overtemp_in(flt[3]), .clock_loss_in(flt[2]),
    .supply_fail_in(flt[1]), .main_supply_uv_in(flt[0]), .supply_irq_out(irq),
    .module_en_out(men), .measure_start_out(meas), .stage_off_out(soff),
    .sleep_req_out(slp), .in_stop_out(stp), .seq_busy_out(busy)
  );
  // ****
  // Tasks
  // ****
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    if (a == pcu_pkg::IRQ_EN_OFFSET) m_irq = v & 32'hff;
    if (a == pcu_pkg::CTRL_STS_OFFSET)
      m_ctrl = (m_ctrl & ~pcu_pkg::CTRL_STS_RW_MASK) | (v & pcu_pkg::CTRL_STS_RW_MASK);
    @(posedge clk_sys);
  endtask : wr
  task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 chk(nm, e, rdata);
    @(posedge clk_sys);
  endtask : rchk
  // Wait a bounded time for a watched level, then compare
  task automatic wt(input int s, input int n, input logic e, input string nm);
    repeat (n) begin
      @(posedge clk_sys);
      #1;
      if (mon[s] === 1'b1) break;
    end
    chk(nm, {31'h0, e}, {31'h0, mon[s]});
    @(posedge clk_sys);
  endtask : wt
  task automatic irq_try(input int i, input logic [7:0] en, input logic [7:0] e);
    logic [7:0] seen;
    seen = 8'h0;
    wr(pcu_pkg::IRQ_EN_OFFSET, {24'h0, en});
    lvl[12:5] <= 8'h1 << i;
    repeat (12) begin
      @(posedge clk_sys);
      #1 seen |= irq;
    end
    chk("irq", {24'h0, e}, {24'h0, seen});
    @(posedge clk_sys);
    lvl[12:5] <= 8'h0;
    repeat (8) @(posedge clk_sys);
  endtask : irq_try
  task automatic print_verdict;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : print_verdict
  // ****
  // Main sequence
  // ****
  initial begin
    void'($urandom(32'hed6be9ee));
    m_irq = pcu_pkg::IRQ_EN_RESET;
    m_ctrl = pcu_pkg::CTRL_STS_RESET;
    repeat (5) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    rchk("irq_en reset", pcu_pkg::IRQ_EN_OFFSET, m_irq);
    chk("busy powering", 32'h1, {31'h0, busy});
    rchk("ctrl reset", pcu_pkg::CTRL_STS_OFFSET, m_ctrl);
    rchk("unmapped", 8'h00, 32'h0);
    wt(4, 60, 1'b1, "powered up");
    chk("busy idle", 32'h0, {31'h0, busy});
    repeat (4) begin
      wr(pcu_pkg::IRQ_EN_OFFSET, $urandom);
      rchk("irq_en", pcu_pkg::IRQ_EN_OFFSET, m_irq);
      wr(pcu_pkg::CTRL_STS_OFFSET, $urandom);
      rchk("ctrl", pcu_pkg::CTRL_STS_OFFSET, m_ctrl);
    end
    for (int i = 0; i < 8; i++) begin
      irq_try(i, 8'h1 << i, 8'h1 << i);
      irq_try(i, ~(8'h1 << i), 8'h0);
    end
    // Driver supply overvoltage: stages off, sleep, stages back
    wr(pcu_pkg::CTRL_STS_OFFSET, 32'h0);
    lvl[4] <= 1'b1;
    wt(1, 10, 1'b1, "attenuators off");
    wt(6, 60, 1'b1, "overvolt sleep");
    lvl[4] <= 1'b0;
    wt(7, 10, 1'b1, "attenuators on");
    wr(pcu_pkg::MODE_OFFSET, 32'h4);
    wt(4, 60, 1'b1, "woken");
    // Overtemperature, immediate then delayed stage shutdown
    lvl[3] <= 1'b1;
    wt(3, 8, 1'b1, "immediate stage off");
    lvl[3] <= 1'b0;
    repeat (10) @(posedge clk_sys);
    wr(pcu_pkg::CTRL_STS_OFFSET, 32'h80);
    lvl[3] <= 1'b1;
    wt(3, 600, 1'b0, "stage held");
    wt(3, 60, 1'b1, "stage off delayed");
    wt(6, 300, 1'b1, "overtemp sleep");
    lvl[3] <= 1'b0;
    wr(pcu_pkg::MODE_OFFSET, 32'h4);
    wt(4, 60, 1'b1, "woken again");
    // Clock loss, masked then enabled
    wr(pcu_pkg::CTRL_STS_OFFSET, 32'h0200_0000);
    lvl[2] <= 1'b1;
    wt(3, 10, 1'b0, "clock loss masked");
    wr(pcu_pkg::CTRL_STS_OFFSET, 32'h0);
    wt(3, 10, 1'b1, "clock loss off");
    lvl[2] <= 1'b0;
    // Transceiver undervoltage, masked then enabled
    wr(pcu_pkg::CTRL_STS_OFFSET, 32'h100);
    lvl[0] <= 1'b1;
    wt(0, 10, 1'b0, "transceiver masked");
    wr(pcu_pkg::CTRL_STS_OFFSET, 32'h0);
    wt(0, 10, 1'b1, "transceiver off");
    lvl[0] <= 1'b0;
    // Stop, write during wake-up, settings come back
    wr(pcu_pkg::IRQ_EN_OFFSET, 32'h5a);
    saved = m_irq;
    wr(pcu_pkg::MODE_OFFSET, 32'h2);
    wt(5, 60, 1'b1, "stop");
    wr(pcu_pkg::MODE_OFFSET, 32'h4);
    wr(pcu_pkg::IRQ_EN_OFFSET, 32'h33);
    wt(4, 60, 1'b1, "stop exit");
    m_irq = saved;
    rchk("restored", pcu_pkg::IRQ_EN_OFFSET, m_irq);
    lvl[1] <= 1'b1;
    wt(6, 60, 1'b1, "fail sleep");
    lvl[1] <= 1'b0;
    // Software Sleep command from running state
    repeat (8) @(posedge clk_sys);
    wr(pcu_pkg::MODE_OFFSET, 32'h4);
    wt(4, 60, 1'b1, "woken last");
    wr(pcu_pkg::MODE_OFFSET, 32'h1);
    wt(6, 60, 1'b1, "sleep command");
    print_verdict();
  end
  // Cuts a hang short
  initial begin
    repeat (20000) @(posedge clk_sys);
    n_errors++;
    print_verdict();
  end
endmodule : power_module_sequencer_test
`default_nettype wire
